// ==== bei_pkg.sv ====
// Shared constants for the break and interrupt entry block and its controller
package bei_pkg;

  // ---------------------------------------------------------------
  // Vector offsets from the vector base
  // ---------------------------------------------------------------
  localparam logic [31:0] BEI_VEC_USER   = 32'h0000_0008;
  localparam logic [31:0] BEI_VEC_IRQ    = 32'h0000_0010;
  localparam logic [31:0] BEI_VEC_BRK    = 32'h0000_0018;
  localparam logic [31:0] BEI_VEC_EXC    = 32'h0000_0020;
  localparam logic [31:0] BEI_BRKI_DEBUG = 32'h0000_0018;
  localparam logic [31:0] BEI_VEC_BASE   = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Link registers written on entry
  // ---------------------------------------------------------------
  localparam logic [4:0] BEI_GPR_IRQ = 5'h0e;
  localparam logic [4:0] BEI_GPR_BRK = 5'h10;
  localparam logic [4:0] BEI_GPR_EXC = 5'h11;

  // ---------------------------------------------------------------
  // Machine status word bit positions and reset value
  // ---------------------------------------------------------------
  localparam int BEI_MSR_IE  = 1;
  localparam int BEI_MSR_BIP = 3;
  localparam int BEI_MSR_EE  = 8;
  localparam int BEI_MSR_EIP = 9;
  localparam int BEI_MSR_UM  = 11;
  localparam int BEI_MSR_UMS = 12;
  localparam int BEI_MSR_VM  = 13;
  localparam int BEI_MSR_VMS = 14;
  localparam logic [31:0] BEI_MSR_RST = 32'h0000_0000;

  // ---------------------------------------------------------------
  // Interrupt use modes and acknowledge codes
  // ---------------------------------------------------------------
  localparam int BEI_IRQ_OFF    = 0;
  localparam int BEI_IRQ_NORMAL = 1;
  localparam int BEI_IRQ_LOWLAT = 2;
  localparam logic [1:0] BEI_ACK_NONE  = 2'h0;
  localparam logic [1:0] BEI_ACK_ENTER = 2'h1;
  localparam logic [1:0] BEI_ACK_RET   = 2'h2;
  localparam logic [1:0] BEI_ACK_REEN  = 2'h3;

  // ---------------------------------------------------------------
  // Controller registers (APB byte offsets) and fields
  // ---------------------------------------------------------------
  localparam logic [7:0] BEI_REG_CMD    = 8'h00;
  localparam logic [7:0] BEI_REG_VECTOR = 8'h04;
  localparam logic [7:0] BEI_REG_STATUS = 8'h08;
  localparam int BEI_CMD_BRK    = 0;
  localparam int BEI_CMD_NMBRK  = 1;
  localparam int BEI_CMD_IRQ    = 2;
  localparam int BEI_ST_BRK     = 0;
  localparam int BEI_ST_IRQ     = 1;
  localparam int BEI_ST_ACK_LSB = 4;
  localparam logic [31:0] BEI_VECTOR_RST = 32'h0000_0000;

endpackage

// ==== bei_link_if.sv ====
// Link between the processor entry logic and the interrupt/break controller
`timescale 1ns/1ps
interface bei_link_if;
  logic        brk_req;               // Maskable break request
  logic        nonmaskable_break_req; // One-cycle non-maskable break
  logic        irq;                   // External interrupt
  logic [31:0] irq_vector;            // Handler address, low-latency mode
  logic [1:0]  irq_ack;               // Acknowledge code, one cycle
  logic        brk_taken;             // Break entry pulse
  logic        irq_taken;             // Interrupt entry pulse

  modport cpu (
    input  brk_req, nonmaskable_break_req, irq, irq_vector,
    output irq_ack, brk_taken, irq_taken
  );
  modport ctl (
    output brk_req, nonmaskable_break_req, irq, irq_vector,
    input  irq_ack, brk_taken, irq_taken
  );
endinterface

// ==== bei_cpu_end.sv ====
// Break, interrupt and user-vector entry logic of the processor pipeline
//
// Decided for this implementation: register access over APB and the register addresses.
`timescale 1ns/1ps
module bei_cpu_end
  import bei_pkg::*;
#(
  parameter logic [31:0] vector_base_param     = BEI_VEC_BASE, // Vector base
  parameter bit          irq_edge_select_param = 1'b0,         // 1: edge interrupt
  parameter int          irq_use_param         = BEI_IRQ_NORMAL, // 0 off, 1, 2 low-lat
  parameter bit          debug_param           = 1'b1          // Debug option
) (
  input  wire logic        pclk,          // Processor clock
  input  wire logic        presetn,       // Async reset, active low
  bei_link_if.cpu          link,          // Controller link
  input  wire logic        dec_valid,     // Decode stage holds an instruction
  input  wire logic [31:0] dec_pc,        // Decode stage instruction address
  input  wire logic        exc_req,       // Exception entry from pipeline
  input  wire logic [31:0] exc_ret_pc,    // Exception return address
  input  wire logic        return_from_break_instr_exec,     // return_from_break_instr executes
  input  wire logic        return_from_interrupt_instr_exec,     // return_from_interrupt_instr executes
  input  wire logic        rted_exec,     // Return from exception executes
  input  wire logic        brki_exec,     // Immediate software break executes
  input  wire logic [31:0] brki_target,   // Its immediate target
  input  wire logic        branch_link_abs_imm_instr_exec,   // branch_link_abs_imm_instr to user vector
  input  wire logic [4:0]  branch_link_abs_imm_instr_rd,     // Its link register
  input  wire logic        msr_wr,        // Software write of the status word
  input  wire logic [31:0] msr_wdata,     // Value written
  output logic             redir_valid_q, // Replace decode instruction, branch
  output logic [31:0]      redir_pc_q,    // Branch target
  output logic             gpr_we_q,      // Register file write
  output logic [4:0]       gpr_waddr_q,   // Register written
  output logic [31:0]      gpr_wdata_q,   // Return address written
  output logic [31:0]      msr_q,         // machine_status_word
  output logic             resv_clr_q,    // Clear reservation
  output logic             sw_bkpt_q      // Software breakpoint to debugger
);

  // ---------------------------------------------------------------
  // Status bit views
  // ---------------------------------------------------------------
  wire logic break_in_progress     = msr_q[BEI_MSR_BIP];
  wire logic exception_in_progress = msr_q[BEI_MSR_EIP];
  wire logic interrupt_enable      = msr_q[BEI_MSR_IE];
  wire logic lowlat                = (irq_use_param == BEI_IRQ_LOWLAT);
  wire logic irq_used              = (irq_use_param != BEI_IRQ_OFF);

  // ---------------------------------------------------------------
  // Edge latch
  // ---------------------------------------------------------------
  logic irq_prev_q;
  logic irq_lat_q;
  logic irq_lat_d;
  logic irq_taken_now;
  logic brk_taken_q;
  logic irq_taken_q;
  logic [1:0] ack_q;
  logic [1:0] ack_d;

  // Rising edge only; a held input does not retrigger
  wire logic irq_rise = link.irq & ~irq_prev_q;
  // Latch ignores the enable; set wins over clear on entry
  assign irq_lat_d = irq_rise | (irq_lat_q & ~irq_taken_now);

  wire logic irq_pending = irq_edge_select_param ? irq_lat_q : link.irq;

  // ---------------------------------------------------------------
  // Entry selection
  // ---------------------------------------------------------------
  wire logic idle_flags = ~break_in_progress & ~exception_in_progress;

  wire logic take_nmb = link.nonmaskable_break_req;
  wire logic take_exc = ~take_nmb & exc_req;
  wire logic take_brk = ~take_nmb & ~exc_req & link.brk_req
                        & idle_flags & dec_valid;
  // Break is decided before the interrupt so it masks a same-cycle interrupt
  wire logic irq_ok   = irq_used & irq_pending & interrupt_enable
                        & idle_flags & dec_valid;
  assign irq_taken_now = ~take_nmb & ~exc_req & ~take_brk & irq_ok;
  wire logic take_usr = ~take_nmb & ~exc_req & ~take_brk & ~irq_taken_now
                        & branch_link_abs_imm_instr_exec;
  wire logic any_brk  = take_nmb | take_brk;
  wire logic any_take = any_brk | take_exc | irq_taken_now | take_usr;

  wire logic [31:0] irq_target = lowlat ? link.irq_vector
                                        : vector_base_param + BEI_VEC_IRQ;

  wire logic debug_bkpt = debug_param & brki_exec
                          & (brki_target == BEI_BRKI_DEBUG);

  // ---------------------------------------------------------------
  // Mode save and restore helpers
  // ---------------------------------------------------------------
  function automatic logic [31:0] save_modes(input logic [31:0] m);
    logic [31:0] r;
    r = m;
    r[BEI_MSR_UMS] = m[BEI_MSR_UM];
    r[BEI_MSR_UM]  = 1'b0;
    r[BEI_MSR_VMS] = m[BEI_MSR_VM];
    r[BEI_MSR_VM]  = 1'b0;
    return r;
  endfunction

  function automatic logic [31:0] restore_modes(input logic [31:0] m);
    logic [31:0] r;
    r = m;
    r[BEI_MSR_UM] = m[BEI_MSR_UMS];
    r[BEI_MSR_VM] = m[BEI_MSR_VMS];
    return r;
  endfunction

  // ---------------------------------------------------------------
  // Next status word
  // ---------------------------------------------------------------
  logic [31:0] msr_d;
  logic [31:0] redir_pc_d;
  logic [4:0]  gpr_waddr_d;
  logic [31:0] gpr_wdata_d;

  always_comb begin
    msr_d       = msr_q;
    redir_pc_d  = redir_pc_q;
    gpr_waddr_d = gpr_waddr_q;
    gpr_wdata_d = gpr_wdata_q;
    if (msr_wr) begin
      msr_d = msr_wdata;
    end
    if (return_from_break_instr_exec) begin
      msr_d = restore_modes(msr_d);
      msr_d[BEI_MSR_BIP] = 1'b0;
    end
    if (return_from_interrupt_instr_exec) begin
      msr_d = restore_modes(msr_d);
      msr_d[BEI_MSR_IE] = 1'b1;
    end
    if (rted_exec) begin
      msr_d = restore_modes(msr_d);
      msr_d[BEI_MSR_EE]  = 1'b1;
      msr_d[BEI_MSR_EIP] = 1'b0;
    end
    if (any_take) begin
      msr_d = save_modes(msr_d);
    end
    if (any_brk) begin
      msr_d[BEI_MSR_BIP] = 1'b1;
      redir_pc_d  = vector_base_param + BEI_VEC_BRK;
      gpr_waddr_d = BEI_GPR_BRK;
      gpr_wdata_d = dec_pc;
    end else if (take_exc) begin
      msr_d[BEI_MSR_EE]  = 1'b0;
      msr_d[BEI_MSR_EIP] = 1'b1;
      redir_pc_d  = vector_base_param + BEI_VEC_EXC;
      gpr_waddr_d = BEI_GPR_EXC;
      gpr_wdata_d = exc_ret_pc;
    end else if (irq_taken_now) begin
      msr_d[BEI_MSR_IE] = 1'b0;
      redir_pc_d  = irq_target;
      gpr_waddr_d = BEI_GPR_IRQ;
      gpr_wdata_d = dec_pc;
    end else if (take_usr) begin
      redir_pc_d  = vector_base_param + BEI_VEC_USER;
      gpr_waddr_d = branch_link_abs_imm_instr_rd;
      gpr_wdata_d = dec_pc;
    end
  end

  // ---------------------------------------------------------------
  // Acknowledge code, low-latency mode only
  // ---------------------------------------------------------------
  // Entry outranks return, return outranks plain re-enable
  assign ack_d = !lowlat                              ? BEI_ACK_NONE  :
                 irq_taken_now                        ? BEI_ACK_ENTER :
                 return_from_interrupt_instr_exec                            ? BEI_ACK_RET   :
                 (~interrupt_enable & msr_d[BEI_MSR_IE]) ? BEI_ACK_REEN :
                                                        BEI_ACK_NONE;

  // ---------------------------------------------------------------
  // Registers
  // ---------------------------------------------------------------
  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      msr_q         <= BEI_MSR_RST;
      irq_prev_q    <= 1'b0;
      irq_lat_q     <= 1'b0;
      ack_q         <= BEI_ACK_NONE;
      brk_taken_q   <= 1'b0;
      irq_taken_q   <= 1'b0;
      redir_valid_q <= 1'b0;
      redir_pc_q    <= 32'h0000_0000;
      gpr_we_q      <= 1'b0;
      gpr_waddr_q   <= 5'h00;
      gpr_wdata_q   <= 32'h0000_0000;
      resv_clr_q    <= 1'b0;
      sw_bkpt_q     <= 1'b0;
    end else begin
      msr_q         <= msr_d;
      irq_prev_q    <= link.irq;
      irq_lat_q     <= irq_lat_d;
      ack_q         <= ack_d;
      brk_taken_q   <= any_brk;
      irq_taken_q   <= irq_taken_now;
      redir_valid_q <= any_take;
      redir_pc_q    <= redir_pc_d;
      gpr_we_q      <= any_take;
      gpr_waddr_q   <= gpr_waddr_d;
      gpr_wdata_q   <= gpr_wdata_d;
      resv_clr_q    <= any_take;
      sw_bkpt_q     <= debug_bkpt;
    end
  end

  assign link.irq_ack   = ack_q;
  assign link.brk_taken = brk_taken_q;
  assign link.irq_taken = irq_taken_q;

endmodule

// ==== bei_ctl_end.sv ====
// Interrupt and break controller driven by software over APB
`timescale 1ns/1ps
module bei_ctl_end
  import bei_pkg::*;
#(
  parameter bit irq_edge_select_param = 1'b0 // Must match the processor end
) (
  input  wire logic        pclk,      // APB clock
  input  wire logic        presetn,   // Async reset, active low
  bei_link_if.ctl          link,      // Processor link
  input  wire logic        psel,      // APB select
  input  wire logic        penable,   // APB access phase
  input  wire logic        pwrite,    // APB write
  input  wire logic [7:0]  paddr,     // APB byte address
  input  wire logic [31:0] pwdata,    // APB write data
  output logic [31:0]      prdata_q,  // APB read data
  output logic             pready_q,  // APB ready
  output logic             pslverr_q  // APB error, unmapped address
);

  // ---------------------------------------------------------------
  // APB decode
  // ---------------------------------------------------------------
  typedef enum logic [1:0] {BS_IDLE = 2'b01, BS_HOLD = 2'b10} bei_bstate_t;
  typedef enum logic [2:0] {
    IS_IDLE = 3'b001, IS_HOLD = 3'b010, IS_GAP = 3'b100
  } bei_istate_t;

  bei_bstate_t bst_q;
  bei_bstate_t bst_d;
  bei_istate_t ist_q;
  bei_istate_t ist_d;
  logic [31:0] vector_q;
  logic [2:0]  ack_seen_q;
  logic [2:0]  ack_seen_d;
  logic        nmb_q;

  wire logic setup   = psel & ~penable;
  wire logic wr_acc  = psel & penable & pready_q & pwrite;
  wire logic hit_cmd = (paddr == BEI_REG_CMD);
  wire logic hit_vec = (paddr == BEI_REG_VECTOR);
  wire logic hit_st  = (paddr == BEI_REG_STATUS);
  wire logic mapped  = hit_cmd | hit_vec | hit_st;
  wire logic cmd_wr  = wr_acc & hit_cmd;
  wire logic [31:0] status_word = {25'h0, ack_seen_q, 2'h0,
                                   ~ist_q[0], ~bst_q[0]};
  wire logic [31:0] rd_word = hit_vec ? vector_q :
                              hit_st  ? status_word : 32'h0000_0000;

  // ---------------------------------------------------------------
  // Break source: hold until taken, release at once after
  // ---------------------------------------------------------------
  always_comb begin
    bst_d = bst_q;
    case (bst_q)
      BS_IDLE: if (cmd_wr && pwdata[BEI_CMD_BRK]) bst_d = BS_HOLD;
      BS_HOLD: if (link.brk_taken) bst_d = BS_IDLE;
      default: bst_d = BS_IDLE;
    endcase
  end

  // ---------------------------------------------------------------
  // Interrupt source: level holds until taken, edge pulses then gaps
  // ---------------------------------------------------------------
  always_comb begin
    ist_d = ist_q;
    case (ist_q)
      IS_IDLE: if (cmd_wr && pwdata[BEI_CMD_IRQ]) ist_d = IS_HOLD;
      IS_HOLD: begin
        if (irq_edge_select_param) ist_d = IS_GAP;
        else if (link.irq_taken) ist_d = IS_IDLE;
      end
      IS_GAP:  ist_d = IS_IDLE;
      default: ist_d = IS_IDLE;
    endcase
  end

  // Sticky acknowledge record; a new code wins over a clear
  genvar g;
  generate
    for (g = 0; g < 3; g++) begin : g_ack
      assign ack_seen_d[g] = (link.irq_ack == 2'(g + 1)) |
        (ack_seen_q[g] & ~(wr_acc & hit_st & pwdata[BEI_ST_ACK_LSB + g]));
    end
  endgenerate

  always_ff @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      bst_q      <= BS_IDLE;
      ist_q      <= IS_IDLE;
      nmb_q      <= 1'b0;
      vector_q   <= BEI_VECTOR_RST;
      ack_seen_q <= 3'h0;
      prdata_q   <= 32'h0000_0000;
      pready_q   <= 1'b0;
      pslverr_q  <= 1'b0;
    end else begin
      bst_q      <= bst_d;
      ist_q      <= ist_d;
      nmb_q      <= cmd_wr & pwdata[BEI_CMD_NMBRK];
      ack_seen_q <= ack_seen_d;
      pready_q   <= 1'b1;
      if (wr_acc && hit_vec) vector_q <= pwdata;
      if (setup) begin
        prdata_q  <= pwrite ? 32'h0000_0000 : rd_word;
        pslverr_q <= ~mapped;
      end
    end
  end

  assign link.brk_req               = (bst_q == BS_HOLD);
  assign link.nonmaskable_break_req = nmb_q;
  assign link.irq                   = (ist_q == IS_HOLD);
  assign link.irq_vector            = vector_q;

endmodule

// ==== bei_link_chk.sv ====
// Concurrent checks on the link between processor end and controller end
`timescale 1ns/1ps
module bei_link_chk
  import bei_pkg::*;
#(
  parameter int irq_use_param = BEI_IRQ_LOWLAT // Interrupt use mode
) (
  input wire logic        pclk,                  // Clock
  input wire logic        presetn,               // Reset, active low
  input wire logic        brk_req,               // Maskable break
  input wire logic        nonmaskable_break_req, // Non-maskable break
  input wire logic        irq,                   // Interrupt
  input wire logic [31:0] irq_vector,            // Handler address
  input wire logic [1:0]  irq_ack,               // Acknowledge code
  input wire logic        brk_taken,             // Break entry pulse
  input wire logic        irq_taken              // Interrupt entry pulse
);
  // ---------------------------------------------------------------
  // Link properties
  // ---------------------------------------------------------------
  // ---------------------------------------------------------------
  default clocking dcb @(posedge pclk); endclocking
  default disable iff (!presetn);
  localparam bit LowLat = (irq_use_param == BEI_IRQ_LOWLAT);

  nm_one_cycle_a: assert property (nonmaskable_break_req |=> !nonmaskable_break_req)
    else $error("non-maskable break held too long");
  nm_taken_a: assert property (nonmaskable_break_req |=> brk_taken)
    else $error("non-maskable break not taken at once");
  brk_held_a: assert property (brk_req && !brk_taken |=> brk_req)
    else $error("break request dropped before taken");
  irq_held_a: assert property (irq && !irq_taken |=> irq)
    else $error("level interrupt dropped before taken");
  entry_excl_a: assert property (!(brk_taken && irq_taken))
    else $error("break and interrupt entered together");
  irq_once_a: assert property (irq_taken |=> !irq_taken)
    else $error("interrupt entered twice in a row");
  ack_enter_a: assert property (LowLat && irq_taken |-> irq_ack == BEI_ACK_ENTER)
    else $error("entry without enter acknowledge");
  ack_cause_a: assert property (irq_ack == BEI_ACK_ENTER |-> irq_taken)
    else $error("enter acknowledge without entry");
  ack_single_a: assert property (irq_ack == BEI_ACK_ENTER |=> irq_ack != BEI_ACK_ENTER)
    else $error("enter acknowledge longer than one cycle");
  vec_stable_a: assert property (LowLat && irq && !irq_taken |=> $stable(irq_vector))
    else $error("handler address changed while interrupt pending");
endmodule

// ==== break_interrupt_entry_tb.sv ====
// Self-checking bench for the processor end and controller end pair
`timescale 1ns/1ps
module break_interrupt_entry_tb
  import bei_pkg::*;
;
  // ---------------------------------------------------------------
  // Signals
  // ---------------------------------------------------------------
  localparam logic [31:0] BASE    = 32'h0000_1000;
  localparam logic [31:0] MK_EN   = 32'h1 << BEI_MSR_IE;
  localparam logic [31:0] MK_BRK  = 32'h1 << BEI_MSR_BIP;
  localparam logic [31:0] MK_EXEN = 32'h1 << BEI_MSR_EE;
  localparam logic [31:0] MK_EXC  = 32'h1 << BEI_MSR_EIP;
  localparam logic [31:0] MK_USR  = 32'h1 << BEI_MSR_UM;
  localparam logic [31:0] MK_USRS = 32'h1 << BEI_MSR_UMS;
  localparam logic [31:0] MK_VRT  = 32'h1 << BEI_MSR_VM;
  localparam logic [31:0] MK_VRTS = 32'h1 << BEI_MSR_VMS;
  logic         pclk = 1'b0;
  logic         presetn = 1'b0;
  logic         psel, penable, pwrite, pready_q, pslverr_q;
  logic [7:0]   paddr;
  logic [31:0]  pwdata, prdata_q, dec_pc, exc_ret_pc, brki_target, msr_wdata;
  logic [31:0]  redir_pc_q, gpr_wdata_q, msr_q, a_pc, vec, e_pc, seed;
  logic [6:0]   pv;
  logic         dec_valid, exc_req, return_from_break_instr_exec, return_from_interrupt_instr_exec, rted_exec, brki_exec;
  logic         branch_link_abs_imm_instr_exec, msr_wr, redir_valid_q, gpr_we_q, resv_clr_q, sw_bkpt_q;
  logic [4:0]   branch_link_abs_imm_instr_rd, gpr_waddr_q, rd;
  logic [32:0]  rd_q[$];
  logic [101:0] rq[$];
  logic [1:0]   aq[$];
  logic         bq[$];
  logic [101:0] nox = 'x;
  int           error_cnt = 0;
  int           total_checks = 0;

  always #12.5 pclk = ~pclk;
  assign {msr_wr, brki_exec, branch_link_abs_imm_instr_exec, exc_req, rted_exec, return_from_interrupt_instr_exec, return_from_break_instr_exec} = pv;

  bei_link_if link();
  bei_cpu_end #(.vector_base_param(BASE), .irq_edge_select_param(1'b0),
    .irq_use_param(BEI_IRQ_LOWLAT), .debug_param(1'b1)) bei_cpu_end_inst (
    .pclk(pclk), .presetn(presetn), .link(link), .dec_valid(dec_valid), .dec_pc(dec_pc),
    .exc_req(exc_req), .exc_ret_pc(exc_ret_pc), .return_from_break_instr_exec(return_from_break_instr_exec), .return_from_interrupt_instr_exec(return_from_interrupt_instr_exec),
    .rted_exec(rted_exec), .brki_exec(brki_exec), .brki_target(brki_target),
    .branch_link_abs_imm_instr_exec(branch_link_abs_imm_instr_exec), .branch_link_abs_imm_instr_rd(branch_link_abs_imm_instr_rd), .msr_wr(msr_wr), .msr_wdata(msr_wdata),
    .redir_valid_q(redir_valid_q), .redir_pc_q(redir_pc_q), .gpr_we_q(gpr_we_q),
    .gpr_waddr_q(gpr_waddr_q), .gpr_wdata_q(gpr_wdata_q), .msr_q(msr_q),
    .resv_clr_q(resv_clr_q), .sw_bkpt_q(sw_bkpt_q));
  bei_ctl_end #(.irq_edge_select_param(1'b0)) bei_ctl_end_inst (
    .pclk(pclk), .presetn(presetn), .link(link), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata_q(prdata_q),
    .pready_q(pready_q), .pslverr_q(pslverr_q));
  bei_link_chk #(.irq_use_param(BEI_IRQ_LOWLAT)) bei_link_chk_inst (
    .pclk(pclk), .presetn(presetn), .brk_req(link.brk_req),
    .nonmaskable_break_req(link.nonmaskable_break_req), .irq(link.irq),
    .irq_vector(link.irq_vector), .irq_ack(link.irq_ack), .brk_taken(link.brk_taken),
    .irq_taken(link.irq_taken));

  // ---------------------------------------------------------------
  // Tasks
  // ---------------------------------------------------------------
  task automatic chk(input logic [101:0] got, input logic [101:0] exp);
    total_checks++;
    if (got !== exp) begin
      error_cnt++;
      $display("unexpected at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  task automatic stop_test();
    if (error_cnt == 0 && total_checks > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask

  // Read: d is the expected {error, data}; write: d[31:0] is the data
  task automatic apb(input logic w, input logic [7:0] a, input logic [32:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= a;
    pwdata <= d[31:0];
    if (!w) rd_q.push_back(d);
    @(posedge pclk);
    penable <= 1'b1;
    @(posedge pclk);
    while (pready_q !== 1'b1) @(posedge pclk);
    psel <= 1'b0;
    penable <= 1'b0;
  endtask

  task automatic pulse(input int k);
    @(posedge pclk);
    pv <= 7'h01 << k;
    @(posedge pclk);
    pv <= 7'h00;
  endtask

  task automatic exp_redir(input logic [31:0] pc, input logic [4:0] r,
                           input logic [31:0] w, input logic [31:0] m);
    rq.push_back({1'b1, pc, r, w, m});
  endtask

  task automatic drain();
    repeat (30) if (rq.size() != 0 || aq.size() != 0 || bq.size() != 0) @(posedge pclk);
    chk(102'(rq.size() + aq.size() + bq.size()), 102'h0);
  endtask

  // ---------------------------------------------------------------
  // Output watcher
  // ---------------------------------------------------------------
  always @(posedge pclk) begin
    if (psel && penable && pready_q && !pwrite)
      chk(102'({pslverr_q, prdata_q}), rd_q.size() != 0 ? 102'(rd_q.pop_front()) : nox);
    if (redir_valid_q !== 1'b0)
      chk({gpr_we_q, redir_pc_q, gpr_waddr_q, gpr_wdata_q, msr_q},
          rq.size() != 0 ? rq.pop_front() : nox);
    if (redir_valid_q !== 1'b0 || resv_clr_q !== 1'b0)
      chk(102'({redir_valid_q, resv_clr_q}), 102'h3);
    if (link.irq_ack !== BEI_ACK_NONE)
      chk(102'(link.irq_ack), aq.size() != 0 ? 102'(aq.pop_front()) : nox);
    if (sw_bkpt_q !== 1'b0)
      chk(102'(sw_bkpt_q), bq.size() != 0 ? 102'(bq.pop_front()) : nox);
  end

  initial begin
    repeat (3000) @(posedge pclk);
    error_cnt++;
    stop_test();
  end

  // ---------------------------------------------------------------
  // Scenarios
  // ---------------------------------------------------------------
  initial begin
    seed = $urandom(32'h4d1678c0);
    {psel, penable, pwrite, paddr, pwdata, pv} = '0;
    {dec_pc, exc_ret_pc, brki_target, msr_wdata, branch_link_abs_imm_instr_rd} = '0;
    dec_valid = 1'b1;
    a_pc = $urandom() & 32'hffff_fffc;
    vec = $urandom() & 32'hffff_fffc;
    e_pc = $urandom() & 32'hffff_fffc;
    rd = 5'(($urandom() % 31) + 1);
    repeat (3) @(posedge pclk);
    presetn <= 1'b1;
    dec_pc <= a_pc;
    exc_ret_pc <= e_pc;
    apb(1'b0, BEI_REG_STATUS, 33'h0);
    apb(1'b0, BEI_REG_VECTOR, {1'b0, BEI_VECTOR_RST});
    apb(1'b0, 8'h0c, {1'b1, 32'h0});
    apb(1'b1, BEI_REG_VECTOR, {1'b0, vec});
    apb(1'b0, BEI_REG_VECTOR, {1'b0, vec});
    apb(1'b0, BEI_REG_CMD, 33'h0);
    msr_wdata <= MK_EN | MK_USR | MK_VRT;
    aq.push_back(BEI_ACK_REEN);
    pulse(6);
    exp_redir(vec, BEI_GPR_IRQ, a_pc, MK_USRS | MK_VRTS);
    aq.push_back(BEI_ACK_ENTER);
    apb(1'b1, BEI_REG_CMD, 33'h4);
    drain();
    exp_redir(BASE + BEI_VEC_BRK, BEI_GPR_BRK, a_pc, MK_BRK);
    apb(1'b1, BEI_REG_CMD, 33'h1);
    drain();
    exp_redir(BASE + BEI_VEC_BRK, BEI_GPR_BRK, a_pc, MK_BRK);
    apb(1'b1, BEI_REG_CMD, 33'h2);
    drain();
    // Interrupt stays pending while a break is in progress
    aq.push_back(BEI_ACK_RET);
    pulse(1);
    apb(1'b1, BEI_REG_CMD, 33'h4);
    apb(1'b0, BEI_REG_STATUS, {1'b0, (32'h7 << BEI_ST_ACK_LSB) | (32'h1 << BEI_ST_IRQ)});
    repeat (8) @(posedge pclk);
    exp_redir(vec, BEI_GPR_IRQ, a_pc, 32'h0);
    aq.push_back(BEI_ACK_ENTER);
    pulse(0);
    drain();
    exp_redir(BASE + BEI_VEC_EXC, BEI_GPR_EXC, e_pc, MK_EXC);
    pulse(3);
    drain();
    aq.push_back(BEI_ACK_RET);
    pulse(1);
    apb(1'b1, BEI_REG_CMD, 33'h4);
    repeat (8) @(posedge pclk);
    exp_redir(vec, BEI_GPR_IRQ, a_pc, MK_EXEN);
    aq.push_back(BEI_ACK_ENTER);
    pulse(2);
    drain();
    msr_wdata <= MK_USR | MK_VRT;
    pulse(6);
    branch_link_abs_imm_instr_rd <= rd;
    exp_redir(BASE + BEI_VEC_USER, rd, a_pc, MK_USRS | MK_VRTS);
    pulse(4);
    drain();
    for (int i = 0; i < 2; i++) begin
      if (i == 0) bq.push_back(1'b1);
      brki_target <= (i == 0) ? BEI_BRKI_DEBUG : BEI_VEC_IRQ;
      pulse(5);
    end
    drain();
    apb(1'b0, BEI_REG_STATUS, {1'b0, 32'h7 << BEI_ST_ACK_LSB});
    apb(1'b1, BEI_REG_STATUS, {1'b0, 32'h7 << BEI_ST_ACK_LSB});
    apb(1'b0, BEI_REG_STATUS, 33'h0);
    stop_test();
  end
endmodule
